// >>> core/spcsm_core.sv
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "spcsm_map.svh"
module spcsm_core import spcsm_pkg::*; #(
    parameter int LACP_CYC = `SPCSM_LACP_PERIOD_NS / `SPCSM_CLK_PERIOD_NS
) (
    input wire logic clock, // 125 MHz
    input wire logic sys_rst, // Async, active high
    input wire logic [11:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Byte enables
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [11:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic [9:0] phyLinkUp, // PHY link, async
    input wire logic [19:0] phySpeed, // Resolved speed, 2b/port, async
    input wire logic [9:0] phyFullDup, // Resolved duplex, async
    input wire logic [9:0] txGood, // MAC event pulses
    input wire logic [9:0] txBad, // MAC event pulses
    input wire logic [9:0] rxGood, // MAC event pulses
    input wire logic [9:0] rxBad, // MAC event pulses
    input wire logic [9:0] txAbort, // MAC event pulses
    input wire logic [9:0] collision, // MAC event pulses
    input wire logic [9:0] dropped, // MAC event pulses
    input wire logic [9:0] rxBcast, // MAC event pulses
    input wire logic [9:0] rxMcast, // MAC event pulses
    input wire logic secCheck, // Source MAC check request
    input wire logic [3:0] secPort, // Port of the check
    input wire logic [47:0] secSrcMac, // Source MAC to check
    output logic secValid, // Check answer pulse
    output logic secAccept, // Check verdict
    input wire logic [9:0] lacpRxSeen, // LACP frame received pulse
    input wire logic [9:0] lacpPartnerActive, // Peer reports active
    output logic [9:0] lacpTxReq, // Send LACP frame pulse
    output logic [9:0] lacpAggOk, // Dynamic aggregation allowed
    output logic [9:0] portEnable, // MAC may send and accept
    output logic [9:0] phyAutoNeg, // Negotiation setting
    output logic [19:0] phySpeedCfg, // Speed setting, 2b/port
    output logic [9:0] phyDuplexCfg, // Duplex setting
    output logic [9:0] pauseTxEn, // May send pause frames
    output logic [9:0] pauseRxEn, // Honour received pause
    output logic [9:0] trunkActive, // Working trunk ports
    output logic [9:0] trunkStandby, // Standby trunk ports
    output logic [9:0] mirrorRxDest, // One-hot RX mirror port
    output logic [9:0] mirrorTxDest, // One-hot TX mirror port
    output logic [9:0] mirrorRxSrc, // RX mirrored sources
    output logic [9:0] mirrorTxSrc, // TX mirrored sources
    output logic mirrorRxCopy, // RX copy made, pulse
    output logic mirrorTxCopy // TX copy made, pulse
);
    spcsm_state_s st;
    spcsm_state_s nx;
    logic doClr;
    logic [`SPCSM_NCNT-1:0][`SPCSM_NPORT-1:0] evt;
    spcsm_pmask_t cfgEn;
    spcsm_pmask_t cfgAct;
    spcsm_pmask_t linkV;
    spcsm_pmask_t dupV;

    // ==========================================================
    // Helpers
    function automatic logic [31:0] applyStrb(input logic [31:0] old,
            input logic [31:0] dat, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = dat[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [3:0] countOnes(input spcsm_pmask_t v);
        logic [3:0] c;
        c = '0;
        for (int i = 0; i < `SPCSM_NPORT; i++) begin
            c = c + {3'h0, v[i]};
        end
        return c;
    endfunction

    // Lowest-numbered eligible ports win, up to four; higher-numbered ones wait in standby
    function automatic spcsm_pmask_t pickWork(input spcsm_pmask_t v);
        spcsm_pmask_t r;
        logic [3:0] n;
        r = '0;
        n = '0;
        for (int i = 0; i < `SPCSM_NPORT; i++) begin
            if (v[i] && n < `SPCSM_MAXWORK) begin
                r[i] = 1'b1;
                n = n + 4'h1;
            end
        end
        return r;
    endfunction

    function automatic spcsm_pmask_t oneHot(input logic [3:0] idx);
        spcsm_pmask_t r;
        r = '0;
        if (idx < 4'(`SPCSM_NPORT)) begin
            r[idx] = 1'b1;
        end
        return r;
    endfunction

    // ==========================================================
    // Event gating
    // A disabled port's MAC events are ignored even if the MAC misbehaves
    assign evt = {rxMcast & st.portEn, rxBcast & st.portEn,
                  dropped & st.portEn, collision & st.portEn,
                  txAbort & st.portEn, rxBad & st.portEn,
                  rxGood & st.portEn, txBad & st.portEn,
                  txGood & st.portEn};
    always_comb begin
        for (int p = 0; p < `SPCSM_NPORT; p++) begin
            cfgEn[p] = st.cfg[p][`SPCSM_CFG_EN];
            cfgAct[p] = st.cfg[p][`SPCSM_CFG_ACT];
        end
    end
    assign linkV = st.stab[`SPCSM_NPORT-1:0];
    assign dupV = st.stab[4*`SPCSM_NPORT-1:3*`SPCSM_NPORT];

    // ==========================================================
    // Next state
    always_comb begin
        logic [11:0] ra;
        logic [3:0] pi;
        logic [3:0] ci;
        logic [31:0] rd;
        logic [1:0] rr;
        logic [31:0] wv;
        logic wErr;
        spcsm_pmask_t lacpMem;
        spcsm_pmask_t e;
        spcsm_pmask_t a;
        spcsm_pmask_t trkA;
        spcsm_pmask_t trkS;
        logic [1:0] fc;
        ra = '0;
        pi = '0;
        ci = '0;
        rd = '0;
        rr = `SPCSM_RESP_OKAY;
        wv = '0;
        wErr = 1'b0;
        lacpMem = '0;
        e = '0;
        a = '0;
        trkA = '0;
        trkS = '0;
        fc = '0;
        nx = st;
        doClr = 1'b0;
        // Register bus, write side
        if (s_axi_awvalid && st.awRdy) begin
            nx.awHeld = 1'b1;
            nx.awAddr = s_axi_awaddr;
            nx.awRdy = 1'b0;
        end
        if (s_axi_wvalid && st.wRdy) begin
            nx.wHeld = 1'b1;
            nx.wData = s_axi_wdata;
            nx.wStrb = s_axi_wstrb;
            nx.wRdy = 1'b0;
        end
        if (nx.awHeld && nx.wHeld && !st.bValid) begin
            ra = nx.awAddr;
            pi = 4'(ra[5:2]);
            if (ra >= `SPCSM_CFG_BASE && ra < `SPCSM_STAT_BASE
                    && pi < 4'(`SPCSM_NPORT)) begin
                wv = applyStrb({23'h0, st.cfg[pi]}, nx.wData, nx.wStrb);
                nx.cfg[pi] = wv[8:0];
            end else if (ra >= `SPCSM_STAT_BASE && ra < `SPCSM_TRK_BASE
                    && pi < 4'(`SPCSM_NPORT)) begin
                wErr = 1'b0; // Status is read-only, write ignored
            end else if (ra >= `SPCSM_TRK_BASE && ra < `SPCSM_TRK_ACT
                    && ra[3:2] < 2'(`SPCSM_NGRP)) begin
                wv = applyStrb({15'h0, st.grpLacp[ra[3:2]], 6'h0,
                    st.grp[ra[3:2]]}, nx.wData, nx.wStrb);
                nx.grp[ra[3:2]] = wv[`SPCSM_NPORT-1:0];
                nx.grpLacp[ra[3:2]] = wv[`SPCSM_GRP_LACP];
            end else if (ra == `SPCSM_TRK_ACT) begin
                wErr = 1'b0;
            end else if (ra == `SPCSM_MIR_CFG) begin
                wv = applyStrb({15'h0, st.mirEn, 4'h0, st.mirTxDst, 4'h0,
                    st.mirRxDst}, nx.wData, nx.wStrb);
                nx.mirRxDst = wv[3:0];
                nx.mirTxDst = wv[`SPCSM_MIR_TXD +: 4];
                nx.mirEn = wv[`SPCSM_MIR_EN];
            end else if (ra == `SPCSM_MIR_SRC) begin
                wv = applyStrb({6'h0, st.mirTxSrc, 6'h0, st.mirRxSrc},
                    nx.wData, nx.wStrb);
                nx.mirRxSrc = wv[`SPCSM_NPORT-1:0];
                nx.mirTxSrc = wv[`SPCSM_SRC_TX +: `SPCSM_NPORT];
            end else if (ra == `SPCSM_CLR) begin
                doClr = nx.wStrb[0] && nx.wData[0];
            end else begin
                wErr = 1'b1;
            end
            nx.bValid = 1'b1;
            nx.bResp = wErr ? `SPCSM_RESP_SLVERR : `SPCSM_RESP_OKAY;
            nx.awHeld = 1'b0;
            nx.wHeld = 1'b0;
        end
        if (st.bValid && s_axi_bready) begin
            nx.bValid = 1'b0;
            nx.awRdy = 1'b1;
            nx.wRdy = 1'b1;
        end
        // Register bus, read side
        if (s_axi_arvalid && st.arRdy) begin
            ra = s_axi_araddr;
            pi = 4'(ra[5:2]);
            ci = 4'(ra[5:2]);
            if (ra >= `SPCSM_CFG_BASE && ra < `SPCSM_STAT_BASE
                    && pi < 4'(`SPCSM_NPORT)) begin
                rd = {23'h0, st.cfg[pi]};
            end else if (ra >= `SPCSM_STAT_BASE && ra < `SPCSM_TRK_BASE
                    && pi < 4'(`SPCSM_NPORT)) begin
                rd = {22'h0, st.trkStby[pi], st.trkAct[pi], st.aggOk[pi],
                    st.secVld[pi], st.fcRx[pi], st.fcTx[pi], dupV[pi],
                    st.stab[`SPCSM_NPORT + 2*pi +: 2], linkV[pi]};
            end else if (ra >= `SPCSM_TRK_BASE && ra < `SPCSM_TRK_ACT
                    && ra[3:2] < 2'(`SPCSM_NGRP)) begin
                rd = {7'h0, st.grpErr[ra[3:2]], 7'h0, st.grpLacp[ra[3:2]],
                    6'h0, st.grp[ra[3:2]]};
            end else if (ra == `SPCSM_TRK_ACT) begin
                rd = {6'h0, st.trkStby, 6'h0, st.trkAct};
            end else if (ra == `SPCSM_MIR_CFG) begin
                rd = {15'h0, st.mirEn, 4'h0, st.mirTxDst, 4'h0, st.mirRxDst};
            end else if (ra == `SPCSM_MIR_SRC) begin
                rd = {6'h0, st.mirTxSrc, 6'h0, st.mirRxSrc};
            end else if (ra == `SPCSM_CLR) begin
                rd = '0;
            end else if (ra >= `SPCSM_CNT_BASE && ra[11] == 1'b0
                    && 4'(ra[9:6]) < 4'(`SPCSM_NPORT)
                    && ci < 4'(`SPCSM_NCNT)) begin
                rd = st.cnt[ra[9:6]][ci];
            end else begin
                rr = `SPCSM_RESP_SLVERR;
            end
            nx.arRdy = 1'b0;
            nx.rValid = 1'b1;
            nx.rData = rd;
            nx.rResp = rr;
        end
        if (st.rValid && s_axi_rready) begin
            nx.rValid = 1'b0;
            nx.arRdy = 1'b1;
        end
        // Counters wrap naturally at 32 bits; clear beats a same-cycle event
        for (int p = 0; p < `SPCSM_NPORT; p++) begin
            for (int c = 0; c < `SPCSM_NCNT; c++) begin
                if (doClr) begin
                    nx.cnt[p][c] = '0;
                end else if (evt[c][p]) begin
                    nx.cnt[p][c] = st.cnt[p][c] + 32'h1;
                end
            end
        end
        // Pin synchronisers: a bit changes once stages two and three agree
        nx.s1 = {phyFullDup, phySpeed, phyLinkUp};
        nx.s2 = st.s1;
        nx.s3 = st.s2;
        for (int i = 0; i < 4*`SPCSM_NPORT; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                nx.stab[i] = st.s3[i];
            end
        end
        // Port control
        for (int p = 0; p < `SPCSM_NPORT; p++) begin
            nx.portEn[p] = cfgEn[p];
            fc = st.cfg[p][`SPCSM_CFG_FC +: 2];
            // Pause only on a full duplex link that came up that way
            nx.fcTx[p] = linkV[p] && dupV[p]
                && (fc == SPCSM_FC_SYM || fc == SPCSM_FC_ASYM);
            nx.fcRx[p] = linkV[p] && dupV[p] && fc == SPCSM_FC_SYM;
            if (!st.cfg[p][`SPCSM_CFG_SEC]) begin
                nx.secVld[p] = 1'b0; // Relearn after re-securing
            end
        end
        // Source address security
        nx.secDone = secCheck;
        nx.secOk = 1'b0;
        if (secCheck && secPort < 4'(`SPCSM_NPORT)) begin
            if (!cfgEn[secPort]) begin
                nx.secOk = 1'b0;
            end else if (!st.cfg[secPort][`SPCSM_CFG_SEC]) begin
                nx.secOk = 1'b1;
            end else if (!st.secVld[secPort]) begin
                nx.secVld[secPort] = 1'b1;
                nx.secMac[secPort] = secSrcMac;
                nx.secOk = 1'b1;
            end else begin
                nx.secOk = st.secMac[secPort] == secSrcMac;
            end
        end
        // Trunk groups
        for (int g = 0; g < `SPCSM_NGRP; g++) begin
            nx.grpErr[g] = 1'b0;
            if (st.grpLacp[g]) begin
                lacpMem = lacpMem | st.grp[g];
                e = st.grp[g] & st.aggOk;
                a = pickWork(e);
                trkA = trkA | a;
                trkS = trkS | (e & ~a);
            end else if (countOnes(st.grp[g]) > `SPCSM_MAXWORK) begin
                nx.grpErr[g] = 1'b1;
            end else begin
                trkA = trkA | st.grp[g];
            end
        end
        nx.trkAct = trkA;
        nx.trkStby = trkS;
        // LACP transmit pacing and aggregation permission
        if (st.lacpTmr >= 32'(LACP_CYC - 1)) begin
            nx.lacpTmr = '0;
        end else begin
            nx.lacpTmr = st.lacpTmr + 32'h1;
        end
        for (int p = 0; p < `SPCSM_NPORT; p++) begin
            nx.lacpTx[p] = lacpMem[p] && cfgEn[p] && linkV[p]
                && (cfgAct[p] ? st.lacpTmr == '0 : lacpRxSeen[p]);
            nx.aggOk[p] = lacpMem[p] && linkV[p]
                && (cfgAct[p] || lacpPartnerActive[p]);
        end
        // Mirroring; equal RX and TX destinations give the one-port mode
        nx.mirRxOh = st.mirEn ? oneHot(st.mirRxDst) : '0;
        nx.mirTxOh = st.mirEn ? oneHot(st.mirTxDst) : '0;
        // No copy is claimed while the destination index is out of range
        nx.mirRxCopy = |nx.mirRxOh
            && |((evt[2] | evt[3]) & st.mirRxSrc);
        nx.mirTxCopy = |nx.mirTxOh
            && |((evt[0] | evt[1]) & st.mirTxSrc);
    end

    // ==========================================================
    // State register
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
            for (int p = 0; p < `SPCSM_NPORT; p++) begin
                st.cfg[p] <= `SPCSM_CFG_RST;
            end
            st.portEn <= '1;
            st.awRdy <= 1'b1;
            st.wRdy <= 1'b1;
            st.arRdy <= 1'b1;
        end else begin
            st <= nx;
        end
    end

    // ==========================================================
    // Outputs
    assign s_axi_awready = st.awRdy;
    assign s_axi_wready = st.wRdy;
    assign s_axi_bvalid = st.bValid;
    assign s_axi_bresp = st.bResp;
    assign s_axi_arready = st.arRdy;
    assign s_axi_rvalid = st.rValid;
    assign s_axi_rdata = st.rData;
    assign s_axi_rresp = st.rResp;
    assign secValid = st.secDone;
    assign secAccept = st.secOk;
    assign lacpTxReq = st.lacpTx;
    assign lacpAggOk = st.aggOk;
    assign portEnable = st.portEn;
    assign pauseTxEn = st.fcTx;
    assign pauseRxEn = st.fcRx;
    assign trunkActive = st.trkAct;
    assign trunkStandby = st.trkStby;
    assign mirrorRxDest = st.mirRxOh;
    assign mirrorTxDest = st.mirTxOh;
    assign mirrorRxSrc = st.mirRxSrc;
    assign mirrorTxSrc = st.mirTxSrc;
    assign mirrorRxCopy = st.mirRxCopy;
    assign mirrorTxCopy = st.mirTxCopy;
    always_comb begin
        for (int p = 0; p < `SPCSM_NPORT; p++) begin
            phyAutoNeg[p] = st.cfg[p][`SPCSM_CFG_ANEG];
            phySpeedCfg[2*p +: 2] = st.cfg[p][`SPCSM_CFG_SPD +: 2];
            phyDuplexCfg[p] = st.cfg[p][`SPCSM_CFG_DUP];
        end
    end

    // ==========================================================
    // Assertions
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    port_disable_a: assert property (
        ##1 (portEnable & ~$past(cfgEn)) == '0)
        else $error("disabled port still enabled");
    clear_counters_a: assert property (
        doClr |=> st.cnt == '0)
        else $error("clear left a counter nonzero");
    rx_good_a: assert property (
        evt[2][3] && !doClr |=> st.cnt[3][2] == $past(st.cnt[3][2]) + 32'h1)
        else $error("rx good count did not step");
    count_wrap_a: assert property (
        st.cnt[0][0] == 32'hFFFFFFFF && evt[0][0] && !doClr
        |=> st.cnt[0][0] == '0)
        else $error("counter did not wrap to zero");
    pause_full_a: assert property (
        ##1 ((pauseTxEn | pauseRxEn) & ~$past(dupV)) == '0)
        else $error("pause enabled without full duplex");
    trunk_max_a: assert property (
        st.grpLacp[0] |=> $countones(trunkActive & $past(st.grp[0])) <= 4)
        else $error("more than four working ports");
    static_work_a: assert property (
        !st.grpLacp[1] && !st.grpLacp[0] && !st.grpLacp[2]
        && countOnes(st.grp[1]) <= `SPCSM_MAXWORK
        |=> (trunkActive & $past(st.grp[1])) == $past(st.grp[1]))
        else $error("static trunk lost a member");
    passive_tx_a: assert property (
        ##1 (lacpTxReq & ~$past(cfgAct) & ~$past(lacpRxSeen)) == '0)
        else $error("passive port sent unprompted");
    both_passive_a: assert property (
        ##1 (lacpAggOk & ~$past(cfgAct | lacpPartnerActive)) == '0)
        else $error("aggregated with both ends passive");
    mirror_dest_a: assert property (
        mirrorRxCopy |-> $onehot(mirrorRxDest))
        else $error("rx copy without a single destination");
    write_resp_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
endmodule

// >>> shared/spcsm_map.svh
`ifndef SPCSM_MAP_SVH
`define SPCSM_MAP_SVH
`define SPCSM_NPORT 10
`define SPCSM_NCNT 9
`define SPCSM_NGRP 3
`define SPCSM_MAXWORK 4'd4
`define SPCSM_CFG_BASE 12'h000
`define SPCSM_STAT_BASE 12'h040
`define SPCSM_TRK_BASE 12'h080
`define SPCSM_TRK_ACT 12'h090
`define SPCSM_MIR_CFG 12'h094
`define SPCSM_MIR_SRC 12'h098
`define SPCSM_CLR 12'h09C
`define SPCSM_CNT_BASE 12'h400
`define SPCSM_CFG_RST 9'h013
`define SPCSM_CFG_EN 0
`define SPCSM_CFG_ANEG 1
`define SPCSM_CFG_SPD 2
`define SPCSM_CFG_DUP 4
`define SPCSM_CFG_FC 5
`define SPCSM_CFG_SEC 7
`define SPCSM_CFG_ACT 8
`define SPCSM_GRP_LACP 16
`define SPCSM_MIR_EN 16
`define SPCSM_MIR_TXD 8
`define SPCSM_SRC_TX 16
`define SPCSM_LACP_PERIOD_NS 1000000000
`define SPCSM_CLK_PERIOD_NS 8
`define SPCSM_RESP_OKAY 2'b00
`define SPCSM_RESP_SLVERR 2'b10
`endif

// >>> shared/spcsm_pkg.sv
`include "spcsm_map.svh"
package spcsm_pkg;
    typedef enum logic [1:0] {SPCSM_FC_OFF, SPCSM_FC_SYM, SPCSM_FC_ASYM}
        spcsm_fc_e;
    typedef logic [`SPCSM_NPORT-1:0] spcsm_pmask_t;
    typedef struct packed {
        logic [`SPCSM_NPORT-1:0][8:0] cfg;
        logic [`SPCSM_NGRP-1:0][`SPCSM_NPORT-1:0] grp;
        logic [`SPCSM_NGRP-1:0] grpLacp;
        logic [3:0] mirRxDst;
        logic [3:0] mirTxDst;
        logic mirEn;
        spcsm_pmask_t mirRxSrc;
        spcsm_pmask_t mirTxSrc;
        logic [`SPCSM_NPORT-1:0][`SPCSM_NCNT-1:0][31:0] cnt;
        logic [4*`SPCSM_NPORT-1:0] s1;
        logic [4*`SPCSM_NPORT-1:0] s2;
        logic [4*`SPCSM_NPORT-1:0] s3;
        logic [4*`SPCSM_NPORT-1:0] stab;
        logic [`SPCSM_NPORT-1:0][47:0] secMac;
        spcsm_pmask_t secVld;
        logic secOk;
        logic secDone;
        spcsm_pmask_t trkAct;
        spcsm_pmask_t trkStby;
        logic [`SPCSM_NGRP-1:0] grpErr;
        spcsm_pmask_t portEn;
        spcsm_pmask_t fcRx;
        spcsm_pmask_t fcTx;
        spcsm_pmask_t aggOk;
        spcsm_pmask_t lacpTx;
        spcsm_pmask_t mirRxOh;
        spcsm_pmask_t mirTxOh;
        logic mirRxCopy;
        logic mirTxCopy;
        logic [31:0] lacpTmr;
        logic awRdy;
        logic wRdy;
        logic awHeld;
        logic wHeld;
        logic [11:0] awAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic arRdy;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
    } spcsm_state_s;
endpackage

// >>> verif/spcsm_link_model.sv
`timescale 1ns/10ps
// ==========================================
// Far-side link partner, passive peer
module spcsm_link_model (
    input wire logic clock, // Core clock
    input wire logic sys_rst, // Async reset
    input wire logic [9:0] lacpTxReq, // Frames sent to peer
    output logic [9:0] phyLinkUp, // Link state
    output logic [19:0] phySpeed, // Resolved speed
    output logic [9:0] phyFullDup, // Resolved duplex
    output logic [9:0] lacpRxSeen, // Peer answer frames
    output logic [9:0] lacpPartnerActive // Peer activity
);
    assign phyLinkUp = 10'h3FF;
    assign phySpeed = {10{2'h1}};
    assign phyFullDup = 10'h3FF;
    assign lacpPartnerActive = 10'h000;
    // Never starts talking, so a passive local end stays silent
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) lacpRxSeen <= 10'h000;
        else lacpRxSeen <= lacpTxReq;
    end
endmodule

// >>> verif/test_switch_port_control_stats_mirror.sv
`timescale 1ns/10ps
// ==========================================
// Bench top
module test_switch_port_control_stats_mirror;
import spcsm_pkg::*;
logic clock, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, secCheck, secValid;
logic secAccept, mirrorRxCopy, mirrorTxCopy;
logic [11:0] s_axi_awaddr, s_axi_araddr;
logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
logic [3:0] s_axi_wstrb, secPort;
logic [1:0] s_axi_bresp, s_axi_rresp, rrsp, wrsp;
logic [47:0] secSrcMac;
logic [19:0] phySpeed, phySpeedCfg;
logic [9:0] phyLinkUp, phyFullDup, lacpRxSeen, lacpPartnerActive;
logic [9:0] lacpTxReq, lacpAggOk, portEnable, phyAutoNeg, phyDuplexCfg;
logic [9:0] pauseTxEn, pauseRxEn, trunkActive, trunkStandby;
logic [9:0] mirrorRxDest, mirrorTxDest, mirrorRxSrc, mirrorTxSrc;
logic [9:0] txGood, txBad, rxGood, rxBad, txAbort, collision, dropped;
logic [9:0] rxBcast, rxMcast;
logic [8:0][9:0] evt;
int seed, errors, comparisons, p, c, n;
assign {rxMcast, rxBcast, dropped, collision, txAbort} = evt[8:4];
assign {rxBad, rxGood, txBad, txGood} = evt[3:0];
spcsm_core #(.LACP_CYC(16)) dut_u (.clock, .sys_rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .phyLinkUp,
    .phySpeed, .phyFullDup, .txGood, .txBad, .rxGood, .rxBad, .txAbort,
    .collision, .dropped, .rxBcast, .rxMcast, .secCheck, .secPort,
    .secSrcMac, .secValid, .secAccept, .lacpRxSeen, .lacpPartnerActive,
    .lacpTxReq, .lacpAggOk, .portEnable, .phyAutoNeg, .phySpeedCfg,
    .phyDuplexCfg, .pauseTxEn, .pauseRxEn, .trunkActive, .trunkStandby,
    .mirrorRxDest, .mirrorTxDest, .mirrorRxSrc, .mirrorTxSrc,
    .mirrorRxCopy, .mirrorTxCopy);
spcsm_link_model peer_u (.clock, .sys_rst, .lacpTxReq, .phyLinkUp,
    .phySpeed, .phyFullDup, .lacpRxSeen, .lacpPartnerActive);
initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
end
function automatic logic [11:0] cntA(input int p, input int c);
    return 12'h400 + 12'(p * 64 + c * 4);
endfunction
task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
        errors++;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
endtask
task wr(input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
        @(posedge clock);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    wrsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clock);
endtask
task rd(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
        @(posedge clock);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clock);
endtask
task pulse(input int c, input int p);
    evt[c][p] <= 1'b1;
    @(posedge clock);
    evt[c][p] <= 1'b0;
    @(posedge clock);
endtask
task close_out;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
endtask
initial begin
    repeat (20000) @(posedge clock);
    errors++;
    close_out();
end
initial begin
    {sys_rst, evt, secCheck, secPort, secSrcMac} = {1'b1, 143'h0};
    seed = 46;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_wstrb} = 7'h0F;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 26'h0;
    s_axi_wdata = 32'h0;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    for (p = 0; p < 10; p++) begin
        rd(12'(4 * p));
        chk(rdat, 32'h0000_0013);
    end
    chk(32'({phyAutoNeg, phyDuplexCfg}), 32'h000F_FFFF);
    chk(32'(phySpeedCfg), 32'h0);
    chk(32'({pauseTxEn, pauseRxEn}), 32'h0);
    wr(12'h018, 32'h0000_0033);
    wr(12'h01C, 32'h0000_0053);
    chk(32'({pauseTxEn[7:6], pauseRxEn[7:6]}), 32'hD);
    wr(12'h014, 32'h0000_0093);
    {secCheck, secPort, secSrcMac} <= {1'b1, 4'd5, 48'h0000_1234_5678};
    @(posedge clock);
    secSrcMac <= 48'h0000_1234_5679;
    @(posedge clock);
    secCheck <= 1'b0;
    chk(32'({secValid, secAccept}), 32'h3);
    @(posedge clock);
    chk(32'({secValid, secAccept}), 32'h2);
    p = ($random(seed) & 32'h7FFF_FFFF) % 10;
    wr(12'(4 * p), 32'h0000_0012);
    pulse(2, p);
    chk(32'(portEnable[p]), 32'h0);
    wr(12'(4 * p), 32'h0000_0013);
    // Disabled-port pulse above must not show in rxGood count
    for (c = 0; c < 9; c++) begin
        n = ($random(seed) & 3) + 1;
        repeat (n) pulse(c, p);
        rd(cntA(p, c));
        chk(rdat, 32'(n));
    end
    wr(12'h09C, 32'h0000_0001);
    chk(32'(wrsp), 32'h0);
    rd(cntA(p, 8));
    chk(rdat, 32'h0);
    rd(12'(12'h040 + 4 * p));
    chk(32'(rdat[5:0]), 32'h0B);
    rd(12'h3F0);
    chk(32'(rrsp), 32'h2);
    wr(12'h3F4, 32'h0);
    chk(32'(wrsp), 32'h2);
    wr(12'h094, 32'h0001_0502);
    wr(12'h098, 32'(1 << p) | 32'h0004_0000);
    chk(32'(mirrorRxDest), 32'h004);
    chk(32'(mirrorTxDest), 32'h020);
    chk(32'(mirrorRxSrc), 32'(1 << p));
    chk(32'(mirrorTxSrc), 32'h004);
    evt[2][p] <= 1'b1;
    evt[0][2] <= 1'b1;
    @(posedge clock);
    evt <= '0;
    @(posedge clock);
    chk(32'({mirrorRxCopy, mirrorTxCopy}), 32'h3);
    pulse(2, 3);
    rd(cntA(3, 2));
    chk(rdat, 32'(1 + (p == 3)));
    wr(12'h084, 32'h0000_0007);
    rd(12'h090);
    chk(rdat, 32'h0000_0007);
    // Port 8 active, port 9 passive, against a passive peer
    wr(12'h020, 32'h0000_0113);
    wr(12'h080, 32'h0001_0300);
    n = 0;
    c = 0;
    repeat (40) begin
        @(posedge clock);
        n = n + 32'(lacpTxReq[8]);
        c = c + 32'(lacpTxReq[9]);
    end
    chk(32'(n > 1 && n < 4), 32'h1);
    chk(32'(c), 32'h0);
    chk(32'(lacpAggOk), 32'h100);
    chk(32'({trunkStandby, trunkActive}), 32'h107);
    close_out();
end
endmodule
